//--- verilog/dbsr_pkg.sv
// shared constants for the debug breakpoint status block
package dbsr_pkg;
   localparam int NUM_SLOTS = 4;
   // byte addresses on the register bus
   localparam logic [7:0] SLOT0_ADDR    = 8'h00;
   localparam logic [7:0] CTRL_ADDR     = 8'h10;
   localparam logic [7:0] STATUS_ADDR   = 8'h14;
   localparam logic [7:0] IRQ_STAT_ADDR = 8'h18;
   localparam logic [7:0] IRQ_MASK_ADDR = 8'h1c;
   // debug control register fields
   localparam int CTRL_LOCAL_POS = 0;  // local enable of slot n at 2n
   localparam int CTRL_GLOBAL_POS = 1; // global enable of slot n at 2n+1
   localparam int CTRL_DETECT_POS = 13;
   localparam int CTRL_TYPE_POS  = 16; // access type of slot n at 16+4n
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   // debug status register fields
   localparam int STAT_ACCESS_POS = 13;
   localparam logic [31:0] STAT_RESET = 32'h0000_0000;
   // access type encodings
   localparam logic [1:0] TYPE_EXEC  = 2'h0;
   localparam logic [1:0] TYPE_WRITE = 2'h1;
   localparam logic [1:0] TYPE_RW    = 2'h3;
   // interrupt events
   localparam int NUM_EVENTS   = 4;
   localparam int EV_REPORT    = 0;
   localparam int EV_ACCESS    = 1;
   localparam int EV_DROPPED   = 2;
   localparam int EV_SMM       = 3;
   localparam logic [3:0] IRQ_RESET = 4'h0;
   typedef enum logic [1:0] {
      HND_IDLE,
      HND_CALL
   } dbsr_hnd_state_type;
endpackage : dbsr_pkg

//--- verilog/dbsr_irq_if.sv
// carrier between the status engine and the interrupt unit
`timescale 1ns/1ps
`default_nettype none
interface dbsr_irq_if;
   logic [3:0]  event_set;
   logic        stat_wr;
   logic        mask_wr;
   logic [3:0]  wdata;
   logic [3:0]  stat;
   logic [3:0]  mask;
   logic        irq;
   modport engine (output event_set, stat_wr, mask_wr, wdata,
                   input stat, mask, irq);
   modport unit   (input event_set, stat_wr, mask_wr, wdata,
                   output stat, mask, irq);
endinterface : dbsr_irq_if
`default_nettype wire

//--- verilog/dbsr_slot.sv
// one breakpoint address slot comparator
`timescale 1ns/1ps
`default_nettype none
module dbsr_slot #(
   parameter int AW = 32
) (
   input  wire logic [AW-1:0] slot_addr_i,
   input  wire logic          local_en_i,
   input  wire logic          global_en_i,
   input  wire logic [1:0]    type_i,
   input  wire logic          fetch_valid_i,
   input  wire logic [AW-1:0] fetch_addr_i,
   input  wire logic          data_valid_i,
   input  wire logic          data_write_i,
   input  wire logic [AW-1:0] data_addr_i,
   output logic               enabled_o,
   output logic               code_hit_o,
   output logic               data_hit_o
);
   // either enable bit arms the slot
   assign enabled_o = local_en_i | global_en_i;
   // type 00 watches instruction fetch only
   assign code_hit_o = fetch_valid_i && type_i == dbsr_pkg::TYPE_EXEC
                       && fetch_addr_i == slot_addr_i;
   // io type never matches here: no io path in this core
   assign data_hit_o = data_valid_i && data_addr_i == slot_addr_i
      && (type_i == dbsr_pkg::TYPE_RW
          || (type_i == dbsr_pkg::TYPE_WRITE && data_write_i));
endmodule : dbsr_slot
`default_nettype wire

//--- verilog/dbsr_irq.sv
// sticky interrupt status, mask and level interrupt
`timescale 1ns/1ps
`default_nettype none
module dbsr_irq (
   input  wire logic core_clk_i,
   input  wire logic rst_b_i,
   dbsr_irq_if.unit  bus
);
   logic [3:0] stat_q;
   logic [3:0] mask_q;
   // write one clears, but a new event in the same cycle wins
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         stat_q <= dbsr_pkg::IRQ_RESET;
      end else begin
         stat_q <= (stat_q & ~({4{bus.stat_wr}} & bus.wdata))
                   | bus.event_set;
      end
   end
   // mask register, same layout as status
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         mask_q <= dbsr_pkg::IRQ_RESET;
      end else if (bus.mask_wr) begin
         mask_q <= bus.wdata;
      end
   end
   assign bus.stat = stat_q;
   assign bus.mask = mask_q;
   assign bus.irq  = |(stat_q & mask_q);
endmodule : dbsr_irq
`default_nettype wire

//--- verilog/dbsr_top.sv
// debug breakpoint status engine with apb register access
//
// Contract
// - a breakpointed stack segment move or pop followed by a protection fault under general detect sets only the access-detected flag.
// - breakpoints matched while the debug fault handler is being called after that fault are not added to the match flags.
// - a pending data breakpoint of a stack segment move or pop is dropped when the next store crosses a 4-Kbyte page or updates accessed or dirty bits.
// - a software, overflow or breakpoint interrupt instruction after a stack segment move or pop clears match flags B0 to B3.
// - a data breakpoint coinciding with a system management interrupt enters the handler mode and drops the breakpoint.
// - an instruction that accesses a debug register and hits a breakpoint reports that breakpoint twice.
// - a matching disabled slot sets its flag only when another slot is enabled.
// - a slot is enabled when its local or global enable bit is set.
// - access type 00 means an instruction execution breakpoint.
//
// The implementer's own choices: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module dbsr_top #(
   parameter int AW = 32
) (
   input  wire logic          core_clk_i,
   input  wire logic          rst_b_i,
   // apb slave
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [7:0]    paddr,
   input  wire logic [31:0]   pwdata,
   output logic               pready,
   output logic [31:0]        prdata,
   output logic               pslverr,
   // retiring instruction, one per cycle
   input  wire logic          instr_valid_i,
   input  wire logic [AW-1:0] fetch_addr_i,
   input  wire logic          data_valid_i,
   input  wire logic          data_write_i,
   input  wire logic [AW-1:0] data_addr_i,
   input  wire logic          stack_segment_load_i,
   input  wire logic          debug_reg_access_i,
   input  wire logic          store_page_cross_i,
   input  wire logic          store_ad_update_i,
   input  wire logic          software_interrupt_i,
   input  wire logic          system_management_interrupt_i,
   // exception outcomes
   output logic               debug_exception_o,
   output logic               smm_entry_o,
   output logic               irq_o
);
   localparam int N = dbsr_pkg::NUM_SLOTS;

   logic [AW-1:0] slot_addr_q [N];
   logic [31:0]   debug_control_register_q;
   logic [31:0]   debug_status_register_q;
   logic [31:0]   prdata_q;
   logic          pslverr_q;
   logic [N-1:0]  enabled;
   logic [N-1:0]  code_hit;
   logic [N-1:0]  data_hit;
   logic [N-1:0]  flag_hit;
   logic [N-1:0]  pend_q;
   logic          pend_valid_q;
   logic          ss_prev_q;
   logic          exc_q;
   logic          exc_again_q;
   logic          smm_q;
   logic          general_detect_enable;
   logic          wr_acc;
   logic          rd_setup;
   logic          addr_ok;
   dbsr_pkg::dbsr_hnd_state_type hnd_q;

   dbsr_irq_if irq_bus ();

   assign general_detect_enable =
      debug_control_register_q[dbsr_pkg::CTRL_DETECT_POS];

   // one comparator per address slot
   for (genvar g = 0; g < N; g++) begin : g_slot
      dbsr_slot #(.AW(AW)) u_slot (
         .slot_addr_i   (slot_addr_q[g]),
         .local_en_i    (debug_control_register_q[
                            dbsr_pkg::CTRL_LOCAL_POS + 2*g]),
         .global_en_i   (debug_control_register_q[
                            dbsr_pkg::CTRL_GLOBAL_POS + 2*g]),
         .type_i        (debug_control_register_q[
                            dbsr_pkg::CTRL_TYPE_POS + 4*g +: 2]),
         .fetch_valid_i (instr_valid_i),
         .fetch_addr_i  (fetch_addr_i),
         .data_valid_i  (instr_valid_i & data_valid_i),
         .data_write_i  (data_write_i),
         .data_addr_i   (data_addr_i),
         .enabled_o     (enabled[g]),
         .code_hit_o    (code_hit[g]),
         .data_hit_o    (data_hit[g])
      );
      // a disabled slot flags only when some other slot is armed
      assign flag_hit[g] = (code_hit[g] | data_hit[g])
         & (enabled[g] | (|(enabled & ~(N'(1) << g))));
   end

   // apb decode; every access completes with no wait state
   assign rd_setup = psel & ~penable;
   assign wr_acc   = psel & penable & pwrite & addr_ok;
   assign addr_ok  = paddr[1:0] == 2'h0
                     && paddr <= dbsr_pkg::IRQ_MASK_ADDR;
   assign pready   = 1'b1;
   assign prdata   = prdata_q;
   assign pslverr  = pslverr_q;

   // read data captured in the setup cycle so it comes from a flop
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         prdata_q  <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else if (rd_setup) begin
         pslverr_q <= ~addr_ok;
         case (paddr)
            dbsr_pkg::CTRL_ADDR:     prdata_q <= debug_control_register_q;
            dbsr_pkg::STATUS_ADDR:   prdata_q <= debug_status_register_q;
            dbsr_pkg::IRQ_STAT_ADDR: prdata_q <= {28'h0, irq_bus.stat};
            dbsr_pkg::IRQ_MASK_ADDR: prdata_q <= {28'h0, irq_bus.mask};
            default: begin
               if (addr_ok) begin
                  prdata_q <= 32'(slot_addr_q[paddr[3:2]]);
               end else begin
                  prdata_q <= 32'h0000_0000;
               end
            end
         endcase
      end
   end

   // breakpoint address slots
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         for (int i = 0; i < N; i++) begin
            slot_addr_q[i] <= '0;
         end
      end else if (wr_acc && paddr < dbsr_pkg::CTRL_ADDR) begin
         slot_addr_q[paddr[3:2]] <= AW'(pwdata);
      end
   end

   // debug control register
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         debug_control_register_q <= dbsr_pkg::CTRL_RESET;
      end else if (wr_acc && paddr == dbsr_pkg::CTRL_ADDR) begin
         debug_control_register_q <= pwdata;
      end
   end

   // interrupt unit writes
   assign irq_bus.stat_wr = wr_acc && paddr == dbsr_pkg::IRQ_STAT_ADDR;
   assign irq_bus.mask_wr = wr_acc && paddr == dbsr_pkg::IRQ_MASK_ADDR;
   assign irq_bus.wdata   = pwdata[3:0];
   assign irq_o           = irq_bus.irq;

   dbsr_irq u_irq (
      .core_clk_i (core_clk_i),
      .rst_b_i    (rst_b_i),
      .bus        (irq_bus.unit)
   );

   // classify the retiring instruction once, in priority order
   logic in_handler;
   logic smi_drop;
   logic det_fault;
   logic store_drop;
   logic swi_clear;
   logic report;
   logic dr_double;
   always_comb begin
      in_handler = hnd_q == dbsr_pkg::HND_CALL;
      smi_drop   = 1'b0;
      det_fault  = 1'b0;
      store_drop = 1'b0;
      swi_clear  = 1'b0;
      report     = 1'b0;
      dr_double  = 1'b0;
      if (instr_valid_i && !in_handler) begin
         if (system_management_interrupt_i && (|(flag_hit & data_hit))) begin
            smi_drop = 1'b1;
         end else if (debug_reg_access_i && general_detect_enable) begin
            det_fault = 1'b1;
         end else if (pend_valid_q
                      && (store_page_cross_i || store_ad_update_i)) begin
            store_drop = 1'b1;
         end else if (ss_prev_q && software_interrupt_i) begin
            swi_clear = 1'b1;
         end else if (!stack_segment_load_i) begin
            report    = pend_valid_q || (|flag_hit);
            dr_double = debug_reg_access_i && (|flag_hit);
         end
      end
   end

   // handler call window: matches while it is open are not flagged
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         hnd_q <= dbsr_pkg::HND_IDLE;
      end else begin
         case (hnd_q)
            dbsr_pkg::HND_IDLE: begin
               if (det_fault) begin
                  hnd_q <= dbsr_pkg::HND_CALL;
               end
            end
            dbsr_pkg::HND_CALL: begin
               if (instr_valid_i) begin
                  hnd_q <= dbsr_pkg::HND_IDLE;
               end
            end
            default: hnd_q <= dbsr_pkg::HND_IDLE;
         endcase
      end
   end

   // the interrupt wipe follows any stack segment load, hit or not
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ss_prev_q <= 1'b0;
      end else if (instr_valid_i) begin
         ss_prev_q <= stack_segment_load_i;
      end
   end

   // data breakpoint of a stack segment load waits for the next one;
   // a stack pointer move right after it reports it cleanly
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pend_q       <= '0;
         pend_valid_q <= 1'b0;
      end else if (instr_valid_i) begin
         if (stack_segment_load_i && !in_handler && !smi_drop
             && !det_fault && (|(flag_hit & data_hit))) begin
            pend_q       <= flag_hit & data_hit;
            pend_valid_q <= 1'b1;
         end else begin
            pend_q       <= '0;
            pend_valid_q <= 1'b0;
         end
      end
   end

   // debug status: software writes, hardware sets win over them
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         debug_status_register_q <= dbsr_pkg::STAT_RESET;
      end else begin
         logic [31:0] nxt;
         nxt = debug_status_register_q;
         if (wr_acc && paddr == dbsr_pkg::STATUS_ADDR) begin
            nxt = pwdata;
         end
         if (swi_clear) begin
            nxt[N-1:0] = '0;
         end
         if (det_fault) begin
            nxt[dbsr_pkg::STAT_ACCESS_POS] = 1'b1;
         end
         if (report) begin
            nxt[N-1:0] = nxt[N-1:0] | pend_q | flag_hit;
         end
         debug_status_register_q <= nxt;
      end
   end

   // exception pulses; a debug register access hit fires twice
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         exc_q       <= 1'b0;
         exc_again_q <= 1'b0;
         smm_q       <= 1'b0;
      end else begin
         exc_q       <= report || det_fault || exc_again_q;
         exc_again_q <= dr_double;
         smm_q       <= smi_drop;
      end
   end
   assign debug_exception_o = exc_q;
   assign smm_entry_o       = smm_q;

   // interrupt events
   assign irq_bus.event_set[dbsr_pkg::EV_REPORT]  = report;
   assign irq_bus.event_set[dbsr_pkg::EV_ACCESS]  = det_fault;
   assign irq_bus.event_set[dbsr_pkg::EV_DROPPED] = store_drop | swi_clear;
   assign irq_bus.event_set[dbsr_pkg::EV_SMM]     = smi_drop;

   // checks
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rst_b_i);

   property p_detect_only;
      det_fault && !(wr_acc && paddr == dbsr_pkg::STATUS_ADDR) |=>
         debug_status_register_q[dbsr_pkg::STAT_ACCESS_POS]
         && $stable(debug_status_register_q[N-1:0]);
   endproperty
   a_detect_only: assert property (p_detect_only)
      else $error("access fault changed match flags");

   sequence s_fault_then_call;
      det_fault ##1 hnd_q == dbsr_pkg::HND_CALL;
   endsequence
   property p_handler_quiet;
      s_fault_then_call ##0 !(wr_acc && paddr == dbsr_pkg::STATUS_ADDR)
         |=> $stable(debug_status_register_q[N-1:0]);
   endproperty
   a_handler_quiet: assert property (p_handler_quiet)
      else $error("match flagged during handler call");

   property p_store_drop;
      store_drop |=> !pend_valid_q && !exc_q;
   endproperty
   a_store_drop: assert property (p_store_drop)
      else $error("pending breakpoint survived page store");

   property p_swi_clear;
      swi_clear |=> debug_status_register_q[N-1:0] == '0;
   endproperty
   a_swi_clear: assert property (p_swi_clear)
      else $error("interrupt did not clear match flags");

   property p_smi_drop;
      instr_valid_i && !in_handler && system_management_interrupt_i
         && (|(flag_hit & data_hit)) && !exc_again_q
         |=> smm_entry_o && !debug_exception_o;
   endproperty
   a_smi_drop: assert property (p_smi_drop)
      else $error("smi did not drop breakpoint");

   property p_double;
      dr_double |=> debug_exception_o ##1 debug_exception_o;
   endproperty
   a_double: assert property (p_double)
      else $error("debug register hit not reported twice");

   property p_lonely_disabled;
      instr_valid_i && enabled == '0 && !pend_valid_q && !swi_clear
         && !(wr_acc && paddr == dbsr_pkg::STATUS_ADDR)
         |=> $stable(debug_status_register_q[N-1:0]);
   endproperty
   a_lonely_disabled: assert property (p_lonely_disabled)
      else $error("disabled slot flagged with none armed");

   property p_exec_type;
      instr_valid_i && enabled[0] && fetch_addr_i == slot_addr_q[0]
         && debug_control_register_q[dbsr_pkg::CTRL_TYPE_POS +: 2]
            == dbsr_pkg::TYPE_EXEC |-> code_hit[0];
   endproperty
   a_exec_type: assert property (p_exec_type)
      else $error("type 00 slot missed a fetch");

   property p_enable;
      enabled[0] == (debug_control_register_q[0]
                     | debug_control_register_q[1]);
   endproperty
   a_enable: assert property (p_enable)
      else $error("slot enable not the or of its bits");
endmodule : dbsr_top
`default_nettype wire

//--- verif/dbsr_top_tb.sv
// self-checking bench for the debug breakpoint status block
`timescale 1ns/1ps
`default_nettype none
module dbsr_top_tb;
   typedef struct packed {
      logic [31:0] ctrl;
      logic [5:0]  flg;
      logic [31:0] fa;
      logic        dv;
      logic        dw;
      logic [31:0] da;
      logic [31:0] stat;
      logic [1:0]  exc;
   } dbsr_row_type;
   localparam logic [7:0]  A_CT  = dbsr_pkg::CTRL_ADDR;
   localparam logic [7:0]  A_ST  = dbsr_pkg::STATUS_ADDR;
   localparam logic [7:0]  A_IS  = dbsr_pkg::IRQ_STAT_ADDR;
   localparam logic [7:0]  A_IM  = dbsr_pkg::IRQ_MASK_ADDR;
   localparam logic [31:0] S_ACC = 32'h1 << dbsr_pkg::STAT_ACCESS_POS;
   localparam logic [31:0] C_DET = 32'h1 << dbsr_pkg::CTRL_DETECT_POS;
   localparam logic [31:0] C_L0  = 32'h0000_0001; // slot 0 local, exec
   localparam logic [31:0] C_G1W = 32'h0010_0008; // slot 1 global, write
   localparam logic [31:0] C_G2R = 32'h0300_0020; // slot 2 global, rw
   // qualifier flags: ss load, dbg reg, page cross, a/d, sw int, smi
   localparam logic [5:0]  F_SS  = 6'h20;
   localparam logic [5:0]  F_DRA = 6'h10;
   localparam logic [5:0]  F_PC  = 6'h08;
   localparam logic [5:0]  F_AD  = 6'h04;
   localparam logic [5:0]  F_SWI = 6'h02;
   localparam logic [5:0]  F_SMI = 6'h01;
   logic        core_clk_i;
   logic        rst_b_i;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic        pready;
   logic [31:0] prdata;
   logic        pslverr;
   logic        instr_valid_i;
   logic [31:0] fetch_addr_i;
   logic        data_valid_i;
   logic        data_write_i;
   logic [31:0] data_addr_i;
   logic [5:0]  flg;
   logic        debug_exception_o;
   logic        smm_entry_o;
   logic        irq_o;
   logic [31:0] rd;
   logic        er;
   int          err_count;
   int          cmp_count;
   int          exc_cnt;
   int          smm_cnt;
   dbsr_row_type rows [8];

   dbsr_top #(.AW(32)) DUT (
      .core_clk_i                    (core_clk_i),
      .rst_b_i                       (rst_b_i),
      .psel                          (psel),
      .penable                       (penable),
      .pwrite                        (pwrite),
      .paddr                         (paddr),
      .pwdata                        (pwdata),
      .pready                        (pready),
      .prdata                        (prdata),
      .pslverr                       (pslverr),
      .instr_valid_i                 (instr_valid_i),
      .fetch_addr_i                  (fetch_addr_i),
      .data_valid_i                  (data_valid_i),
      .data_write_i                  (data_write_i),
      .data_addr_i                   (data_addr_i),
      .stack_segment_load_i          (flg[5]),
      .debug_reg_access_i            (flg[4]),
      .store_page_cross_i            (flg[3]),
      .store_ad_update_i             (flg[2]),
      .software_interrupt_i          (flg[1]),
      .system_management_interrupt_i (flg[0]),
      .debug_exception_o             (debug_exception_o),
      .smm_entry_o                   (smm_entry_o),
      .irq_o                         (irq_o)
   );

   // 20 MHz core clock
   initial begin
      core_clk_i = 1'b0;
      forever #25 core_clk_i = ~core_clk_i;
   end

   // pulses are counted mid-cycle, well clear of the launching edge
   always @(negedge core_clk_i) begin
      if (debug_exception_o === 1'b1) exc_cnt++;
      if (smm_entry_o === 1'b1) smm_cnt++;
   end

   task automatic final_report;
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : final_report

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // one apb transfer; waits an edge first so releases never collide
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge core_clk_i);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge core_clk_i);
      penable <= 1'b1;
      // only the watchdog ends a wait for the slave
      do begin
         @(posedge core_clk_i);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr

   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd, e);
   endtask : rdc

   task automatic ci(input logic e);
      @(negedge core_clk_i);
      chk({31'h0, irq_o}, {31'h0, e});
      @(posedge core_clk_i);
   endtask : ci

   // one retiring instruction; entered just after an edge
   task automatic step(input logic [5:0] f, input logic [31:0] fa,
                       input logic dv, input logic dw,
                       input logic [31:0] da);
      instr_valid_i <= 1'b1;
      flg           <= f;
      fetch_addr_i  <= fa;
      data_valid_i  <= dv;
      data_write_i  <= dw;
      data_addr_i   <= da;
      @(posedge core_clk_i);
   endtask : step

   task automatic idle(input int n);
      instr_valid_i <= 1'b0;
      flg           <= 6'h00;
      data_valid_i  <= 1'b0;
      repeat (n) @(posedge core_clk_i);
   endtask : idle

   task automatic prep(input logic [31:0] c);
      wr(A_CT, c);
      wr(A_ST, 32'h0);
      wr(A_IS, 32'hf);
      exc_cnt = 0;
      smm_cnt = 0;
   endtask : prep

   // hang guard, far beyond the few hundred cycles needed
   initial begin
      #(50 * 20000);
      err_count++;
      final_report();
   end

   initial begin
      rst_b_i = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      instr_valid_i = 1'b0;
      fetch_addr_i = 32'h0;
      data_valid_i = 1'b0;
      data_write_i = 1'b0;
      data_addr_i = 32'h0;
      flg = 6'h00;
      err_count = 0;
      cmp_count = 0;
      exc_cnt = 0;
      smm_cnt = 0;
      // ctrl, flags, fetch, dv, dw, data addr, status, pulses (3: skip)
      rows = '{
         '{C_L0, 6'h00, 32'h1000, 1'b0, 1'b0, 32'h0, 32'h1, 2'h1},
         '{C_G1W, 6'h00, 32'h0800, 1'b1, 1'b1, 32'h2000, 32'h2, 2'h1},
         '{C_G2R, 6'h00, 32'h0800, 1'b1, 1'b0, 32'h3000, 32'h4, 2'h1},
         '{C_G1W, 6'h00, 32'h0800, 1'b1, 1'b0, 32'h2000, 32'h0, 2'h0},
         '{C_L0, 6'h00, 32'h4000, 1'b0, 1'b0, 32'h0, 32'h8, 2'h1},
         '{32'h0, 6'h00, 32'h4000, 1'b0, 1'b0, 32'h0, 32'h0, 2'h0},
         '{32'h0002_0001, 6'h00, 32'h1000, 1'b0, 1'b0, 32'h0, 32'h0, 2'h0},
         '{C_L0, F_DRA, 32'h1000, 1'b0, 1'b0, 32'h0, 32'h1, 2'h2}
      };
      repeat (6) @(posedge core_clk_i);
      rst_b_i <= 1'b1;
      // reset values, unmapped and unaligned accesses
      rdc(A_CT, dbsr_pkg::CTRL_RESET);
      rdc(A_ST, dbsr_pkg::STAT_RESET);
      rdc(A_IS, {28'h0, dbsr_pkg::IRQ_RESET});
      rdc(A_IM, {28'h0, dbsr_pkg::IRQ_RESET});
      ci(1'b0);
      rdc(8'h20, 32'h0);
      chk({31'h0, er}, 32'h1);
      apb(1'b1, 8'h12, 32'hffff_ffff);
      chk({31'h0, er}, 32'h1);
      for (int i = 0; i < 4; i++) begin
         wr(dbsr_pkg::SLOT0_ADDR + 8'(4 * i), 32'(32'h1000 * (i + 1)));
         rdc(dbsr_pkg::SLOT0_ADDR + 8'(4 * i), 32'(32'h1000 * (i + 1)));
      end
      $display("test registers done");
      // ordinary single-instruction cases
      foreach (rows[i]) begin
         prep(rows[i].ctrl);
         step(rows[i].flg, rows[i].fa, rows[i].dv, rows[i].dw, rows[i].da);
         idle(3);
         rdc(A_ST, rows[i].stat);
         if (rows[i].exc != 2'h3) chk(32'(exc_cnt), 32'(rows[i].exc));
      end
      $display("test table done");
      // pending report reaches status, then interrupt mask and clear
      prep(C_G1W);
      wr(A_IM, 32'h0);
      step(F_SS, 32'h0800, 1'b1, 1'b1, 32'h2000);
      step(6'h00, 32'h0804, 1'b0, 1'b0, 32'h0);
      idle(3);
      rdc(A_ST, 32'h2);
      chk(32'(exc_cnt), 32'h1);
      ci(1'b0);
      wr(A_IM, 32'h1);
      ci(1'b1);
      wr(A_IS, 32'h1);
      ci(1'b0);
      rdc(A_IS, 32'h0);
      $display("test pending done");
      // protection fault after a pending hit, handler call ignored
      prep(C_G1W | C_L0 | C_DET);
      step(F_SS, 32'h0800, 1'b1, 1'b1, 32'h2000);
      step(F_DRA, 32'h0804, 1'b0, 1'b0, 32'h0);
      step(6'h00, 32'h1000, 1'b0, 1'b0, 32'h0);
      idle(3);
      rdc(A_ST, S_ACC);
      apb(1'b0, A_IS, 32'h0);
      chk(rd & 32'h2, 32'h2);
      step(6'h00, 32'h1000, 1'b0, 1'b0, 32'h0);
      idle(3);
      rdc(A_ST, S_ACC | 32'h1);
      $display("test fault done");
      // page-crossing store and a/d update both drop the pending hit
      for (int k = 0; k < 2; k++) begin
         prep(C_G1W);
         step(F_SS, 32'h0800, 1'b1, 1'b1, 32'h2000);
         step(k == 0 ? F_PC : F_AD, 32'h0804, 1'b1, 1'b1, 32'h5ffe);
         idle(3);
         rdc(A_ST, 32'h0);
         chk(32'(exc_cnt), 32'h0);
         rdc(A_IS, 32'h4);
      end
      $display("test store drop done");
      // software interrupt after ss load wipes all match flags
      prep(C_G1W | C_L0);
      step(6'h00, 32'h1000, 1'b0, 1'b0, 32'h0);
      step(F_SS, 32'h0800, 1'b1, 1'b1, 32'h2000);
      step(F_SWI, 32'h0804, 1'b0, 1'b0, 32'h0);
      idle(3);
      rdc(A_ST, 32'h0);
      rdc(A_IS, 32'h5);
      $display("test interrupt clear done");
      // data hit together with smi goes to handler mode only
      prep(C_G1W);
      step(F_SMI, 32'h0800, 1'b1, 1'b1, 32'h2000);
      idle(3);
      rdc(A_ST, 32'h0);
      chk(32'(smm_cnt), 32'h1);
      chk(32'(exc_cnt), 32'h0);
      rdc(A_IS, 32'h8);
      $display("test smi done");
      // reset in mid-run brings back the control, interrupt status and slot 0 reset values
      rst_b_i <= 1'b0;
      repeat (2) @(posedge core_clk_i);
      rst_b_i <= 1'b1;
      rdc(A_CT, dbsr_pkg::CTRL_RESET);
      rdc(A_IS, {28'h0, dbsr_pkg::IRQ_RESET});
      rdc(dbsr_pkg::SLOT0_ADDR, 32'h0);
      $display("test reset done");
      final_report();
   end
endmodule : dbsr_top_tb
`default_nettype wire
